// ### rtl/oag_pkg.sv
package oag_pkg;

  // ----------------------------------------------------------------
  // Addressing modes and operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_REG, MODE_IMM, MODE_DP, MODE_ABS, MODE_XIND
  } oag_mode_t;

  typedef enum logic [4:0] {
    OP_ADC, OP_AND, OP_CMP, OP_CMPX, OP_CMPY, OP_EOR, OP_LDA, OP_LDX,
    OP_LDY, OP_OR, OP_SBC, OP_STA, OP_STX, OP_STY, OP_XMA, OP_ASL,
    OP_BIT, OP_DEC, OP_INC, OP_LSR, OP_ROL, OP_ROR, OP_MOV, OP_SET1,
    OP_CLR1
  } oag_op_t;

  typedef enum logic [2:0] {
    RSEL_A, RSEL_X, RSEL_Y, RSEL_C, RSEL_STATUS
  } oag_rsel_t;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  ZERO_PAGE        = 8'h00;
  localparam logic [7:0]  SHARED_TMR_ADDR  = 8'hEC;
  localparam logic [15:0] ADDR_RST         = 16'h0000;
  localparam logic [7:0]  BYTE_RST         = 8'h00;
  localparam logic [7:0]  CKCTL_RST        = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    oag_mode_t  mode;
    oag_op_t    op;
    oag_rsel_t  rsel;
    logic [7:0] op1;
    logic [7:0] op2;
  } oag_req_t;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic        mem_access;
    logic        use_imm;
    logic        use_reg;
    oag_rsel_t   rsel;
    logic [7:0]  imm;
    logic [15:0] ea;
  } oag_rsp_t;

  // Decode answer while idle and after reset
  localparam oag_rsp_t RSP_RST = '0;

endpackage : oag_pkg

// ### rtl/oag_shared_reg.sv
`timescale 1ns/1ps
module oag_shared_reg (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Core data access
  input  wire logic       acc_en,
  input  wire logic       acc_wr,
  input  wire logic       acc_bitop,
  input  wire logic [7:0] acc_addr,
  input  wire logic [7:0] acc_wdata,
  input  wire logic [7:0] interval_timer_count,
  // Results
  output logic            rd_hit,
  output logic [7:0]      rd_data,
  output logic [7:0]      clock_timer_control,
  output logic            bitop_refused
);

  typedef struct packed {
    logic       rd_hit;
    logic [7:0] rd_data;
    logic [7:0] ckctl;
    logic       refused;
  } oag_sr_state_t;

  oag_sr_state_t s_q;
  oag_sr_state_t s_d;
  logic          hit;

  always_comb begin
    s_d = s_q;
    hit = acc_en && (acc_addr == oag_pkg::SHARED_TMR_ADDR);
    s_d.rd_hit = hit && !acc_wr;
    s_d.refused = 1'b0;
    // [RQ11] Read count, write ctrl
    if (hit && !acc_wr) begin
      s_d.rd_data = interval_timer_count;
    end else if (hit && acc_wr && !acc_bitop) begin
      s_d.ckctl = acc_wdata;
    end
    // [RQ12] Bit ops dropped
    if (hit && acc_wr && acc_bitop) begin
      s_d.refused = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{1'b0, oag_pkg::BYTE_RST, oag_pkg::CKCTL_RST, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_hit              = s_q.rd_hit;
  assign rd_data             = s_q.rd_data;
  assign clock_timer_control = s_q.ckctl;
  assign bitop_refused       = s_q.refused;

endmodule : oag_shared_reg

// ### rtl/oag_top.sv
// Contract
// [RQ1] Register mode picks A, X, Y, C or status word only; no memory access.
// [RQ2] Immediate mode uses second byte as operand, no memory read.
// [RQ3] Page flag set: address is paging register high, operand byte low.
// [RQ4] Direct page mode: second byte is offset inside current page.
// [RQ5] Absolute: second byte low address, third byte high address.
// [RQ6] Three-byte absolute reaches whole 64K space without paging.
// [RQ7] Absolute accepted for ALU, compare, load and store operations.
// [RQ8] Absolute accepted for memory shifts, bit, inc, dec, rotate.
// [RQ9] X-indexed no offset uses X as address within direct page.
// [RQ10] X-indexed allowed for ALU ops, LDA, STA and XMA.
// [RQ11] Shared timer address: read gives count, write sets control.
// [RQ12] Software uses whole-register moves there, not bit set or clear.
// [RQ13] Page flag clear: direct page is page zero.
`timescale 1ns/1ps
module oag_top (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Decode request
  input  wire oag_pkg::oag_req_t req,
  input  wire logic              page_flag,
  input  wire logic [7:0]        ram_paging_register,
  input  wire logic [7:0]        x_index,
  // Shared timer register access
  input  wire logic              acc_en,
  input  wire logic              acc_wr,
  input  wire logic              acc_bitop,
  input  wire logic [7:0]        acc_addr,
  input  wire logic [7:0]        acc_wdata,
  input  wire logic [7:0]        interval_timer_count,
  // Decode answer
  output oag_pkg::oag_rsp_t      rsp,
  // Shared timer results
  output logic                   tmr_rd_hit,
  output logic [7:0]             tmr_rd_data,
  output logic [7:0]             clock_timer_control,
  output logic                   bitop_refused
);

  // ----------------------------------------------------------------
  // Address forming
  // ----------------------------------------------------------------
  // Page base is shared by direct page and X-indexed modes
  function automatic logic [7:0] page_base(input logic g,
                                           input logic [7:0] page_reg);
    // [RQ3] Paging register high
    if (g) begin
      page_base = page_reg;
    end else begin
      // [RQ13] Page zero default
      page_base = oag_pkg::ZERO_PAGE;
    end
  endfunction : page_base

  // Direct page address from a low byte
  function automatic logic [15:0] page_addr(input logic       g,
                                            input logic [7:0] page_reg,
                                            input logic [7:0] low);
    page_addr = {page_base(g, page_reg), low};
  endfunction : page_addr

  // ----------------------------------------------------------------
  // Register operands
  // ----------------------------------------------------------------
  // [RQ1] Five registers only
  // Listed by name, so a reordered enum cannot widen the set
  function automatic logic reg_ok(input oag_pkg::oag_rsel_t rsel);
    case (rsel)
      oag_pkg::RSEL_A,
      oag_pkg::RSEL_X,
      oag_pkg::RSEL_Y,
      oag_pkg::RSEL_C,
      oag_pkg::RSEL_STATUS: reg_ok = 1'b1;
      default:              reg_ok = 1'b0;
    endcase
  endfunction : reg_ok

  // ----------------------------------------------------------------
  // Legal operations
  // ----------------------------------------------------------------
  // [RQ7] Absolute ALU ops
  function automatic logic abs_ok(input oag_pkg::oag_op_t op);
    case (op)
      oag_pkg::OP_ADC,
      oag_pkg::OP_AND,
      oag_pkg::OP_CMP,
      oag_pkg::OP_CMPX,
      oag_pkg::OP_CMPY,
      oag_pkg::OP_EOR,
      oag_pkg::OP_LDA,
      oag_pkg::OP_LDX,
      oag_pkg::OP_LDY,
      oag_pkg::OP_OR,
      oag_pkg::OP_SBC,
      oag_pkg::OP_STA,
      oag_pkg::OP_STX,
      oag_pkg::OP_STY: abs_ok = 1'b1;
      // [RQ8] Absolute memory ops
      oag_pkg::OP_ASL,
      oag_pkg::OP_BIT,
      oag_pkg::OP_DEC,
      oag_pkg::OP_INC,
      oag_pkg::OP_LSR,
      oag_pkg::OP_ROL,
      oag_pkg::OP_ROR: abs_ok = 1'b1;
      default: abs_ok = 1'b0;
    endcase
  endfunction : abs_ok

  // [RQ10] X-indexed op set
  function automatic logic xind_ok(input oag_pkg::oag_op_t op);
    case (op)
      oag_pkg::OP_ADC,
      oag_pkg::OP_AND,
      oag_pkg::OP_CMP,
      oag_pkg::OP_EOR,
      oag_pkg::OP_LDA,
      oag_pkg::OP_OR,
      oag_pkg::OP_SBC,
      oag_pkg::OP_STA,
      oag_pkg::OP_XMA: xind_ok = 1'b1;
      default: xind_ok = 1'b0;
    endcase
  endfunction : xind_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    oag_pkg::oag_rsp_t rsp;
  } oag_state_t;

  oag_state_t s_q;
  oag_state_t s_d;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // One-cycle latency keeps every output on a flip-flop
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid      = req.valid;
    s_d.rsp.illegal    = 1'b0;
    s_d.rsp.mem_access = 1'b0;
    s_d.rsp.use_imm    = 1'b0;
    s_d.rsp.use_reg    = 1'b0;
    s_d.rsp.rsel       = oag_pkg::RSEL_A;
    s_d.rsp.imm        = oag_pkg::BYTE_RST;
    s_d.rsp.ea         = oag_pkg::ADDR_RST;
    if (req.valid) begin
      case (req.mode)
        oag_pkg::MODE_REG: begin
          // [RQ1] Register operand only
          s_d.rsp.use_reg = 1'b1;
          s_d.rsp.rsel    = req.rsel;
          s_d.rsp.illegal = !reg_ok(req.rsel);
        end
        oag_pkg::MODE_IMM: begin
          // [RQ2] Operand byte is data
          s_d.rsp.use_imm = 1'b1;
          s_d.rsp.imm     = req.op1;
        end
        oag_pkg::MODE_DP: begin
          // [RQ4] Offset in page
          s_d.rsp.mem_access = 1'b1;
          s_d.rsp.ea = page_addr(page_flag, ram_paging_register, req.op1);
        end
        oag_pkg::MODE_ABS: begin
          // [RQ5] Low then high byte
          // [RQ6] Full 64K, no paging
          s_d.rsp.mem_access = abs_ok(req.op);
          s_d.rsp.illegal    = !abs_ok(req.op);
          s_d.rsp.ea         = {req.op2, req.op1};
        end
        oag_pkg::MODE_XIND: begin
          // [RQ9] X in direct page
          s_d.rsp.mem_access = xind_ok(req.op);
          s_d.rsp.illegal    = !xind_ok(req.op);
          s_d.rsp.ea = page_addr(page_flag, ram_paging_register, x_index);
        end
        default: begin
          s_d.rsp.illegal = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{rsp: oag_pkg::RSP_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  assign rsp = s_q.rsp;

  // ----------------------------------------------------------------
  // Shared timer address
  // ----------------------------------------------------------------
  // [RQ11] Split read and write
  oag_shared_reg u_shared (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .acc_en               (acc_en),
    .acc_wr               (acc_wr),
    .acc_bitop            (acc_bitop),
    .acc_addr             (acc_addr),
    .acc_wdata            (acc_wdata),
    .interval_timer_count (interval_timer_count),
    .rd_hit               (tmr_rd_hit),
    .rd_data              (tmr_rd_data),
    .clock_timer_control  (clock_timer_control),
    .bitop_refused        (bitop_refused)
  );

endmodule : oag_top

// ### testbench/oag_top_chk.sv
`timescale 1ns/1ps
module oag_top_chk (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Request side
  input wire oag_pkg::oag_req_t req,
  input wire logic              page_flag,
  input wire logic [7:0]        ram_paging_register,
  input wire logic [7:0]        x_index,
  // Timer access
  input wire logic              acc_en,
  input wire logic              acc_wr,
  input wire logic              acc_bitop,
  input wire logic [7:0]        acc_addr,
  input wire logic [7:0]        acc_wdata,
  input wire logic [7:0]        interval_timer_count,
  // Answers
  input wire oag_pkg::oag_rsp_t rsp,
  input wire logic              tmr_rd_hit,
  input wire logic [7:0]        tmr_rd_data,
  input wire logic [7:0]        clock_timer_control,
  input wire logic              bitop_refused
);
  // ----------
  // Helpers
  // ----------
  // Idle cycles map to 7, which no mode uses
  wire logic [2:0] md  = req.valid ? req.mode : 3'h7;
  wire logic       hit = acc_en && acc_addr == oag_pkg::SHARED_TMR_ADDR;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_abs_addr:
    assert property (md == oag_pkg::MODE_ABS && req.op == oag_pkg::OP_LDA
      |=> !rsp.illegal && rsp.ea == {$past(req.op2), $past(req.op1)})
    else $error("absolute address wrong");
  chk_page_high:
    assert property (md == oag_pkg::MODE_DP && page_flag |=> rsp.illegal
      || rsp.ea == {$past(ram_paging_register), $past(req.op1)})
    else $error("paged address wrong");
  chk_xind_addr:
    assert property (md == oag_pkg::MODE_XIND && req.op == oag_pkg::OP_XMA
      |=> !rsp.illegal && rsp.ea[7:0] == $past(x_index))
    else $error("indexed address wrong");
  chk_reg_nomem:
    assert property (md == oag_pkg::MODE_REG |=> !rsp.mem_access)
    else $error("register mode touched memory");
  chk_imm_data:
    assert property (md == oag_pkg::MODE_IMM |=> rsp.illegal
      || (!rsp.mem_access && rsp.imm == $past(req.op1)))
    else $error("immediate operand wrong");
  chk_tmr_read:
    assert property (hit && !acc_wr
      |=> tmr_rd_hit && tmr_rd_data == $past(interval_timer_count))
    else $error("shared read wrong");
  chk_tmr_write:
    assert property (hit && acc_wr && !acc_bitop
      |=> clock_timer_control == $past(acc_wdata))
    else $error("shared write wrong");
  chk_bit_refuse:
    assert property (hit && acc_wr && acc_bitop
      |=> bitop_refused && $stable(clock_timer_control))
    else $error("bit write not refused");
  chk_dp_zero:
    assert property (md == oag_pkg::MODE_DP && !page_flag
      |=> rsp.ea == {8'h00, $past(req.op1)})
    else $error("page zero address wrong");
  chk_abs_nopage:
    assert property (md == oag_pkg::MODE_ABS && page_flag
      && req.op == oag_pkg::OP_ROR |=> !rsp.illegal
      && rsp.ea == {$past(req.op2), $past(req.op1)})
    else $error("absolute memory op wrong");
endmodule : oag_top_chk

bind oag_top oag_top_chk i_chk (
  .sys_clk              (sys_clk),
  .rst                  (rst),
  .req                  (req),
  .page_flag            (page_flag),
  .ram_paging_register  (ram_paging_register),
  .x_index              (x_index),
  .acc_en               (acc_en),
  .acc_wr               (acc_wr),
  .acc_bitop            (acc_bitop),
  .acc_addr             (acc_addr),
  .acc_wdata            (acc_wdata),
  .interval_timer_count (interval_timer_count),
  .rsp                  (rsp),
  .tmr_rd_hit           (tmr_rd_hit),
  .tmr_rd_data          (tmr_rd_data),
  .clock_timer_control  (clock_timer_control),
  .bitop_refused        (bitop_refused)
);

// ### testbench/oag_top_tb.sv
`timescale 1ns/1ps
module oag_top_tb;
  logic              sys_clk = 1'h0, rst = 1'h1;
  oag_pkg::oag_req_t req = '0, pv = '0;
  oag_pkg::oag_rsp_t rsp;
  logic [7:0]  ram_paging_register = 8'h00, x_index = 8'h00;
  logic [7:0]  acc_addr = 8'h00, acc_wdata = 8'h00;
  logic [7:0]  interval_timer_count = 8'h00;
  logic        page_flag = 1'h0, acc_en = 1'h0, acc_wr = 1'h0;
  logic        acc_bitop = 1'h0, tmr_rd_hit, bitop_refused, pp;
  logic [7:0]  tmr_rd_data, clock_timer_control, pr, px, pt, ce;
  logic [2:0]  pa;
  logic [31:0] seed = 32'h9988052C;
  int          errors = 0, checked = 0;
  oag_top i_dut (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .req                  (req),
    .page_flag            (page_flag),
    .ram_paging_register  (ram_paging_register),
    .x_index              (x_index),
    .acc_en               (acc_en),
    .acc_wr               (acc_wr),
    .acc_bitop            (acc_bitop),
    .acc_addr             (acc_addr),
    .acc_wdata            (acc_wdata),
    .interval_timer_count (interval_timer_count),
    .rsp                  (rsp),
    .tmr_rd_hit           (tmr_rd_hit),
    .tmr_rd_data          (tmr_rd_data),
    .clock_timer_control  (clock_timer_control),
    .bitop_refused        (bitop_refused)
  );
  always #5 sys_clk = ~sys_clk;
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Page byte that direct page and indexed modes expect
  function automatic logic [7:0] exp_page(input logic       g,
                                          input logic [7:0] r);
    return g ? r : 8'h00;
  endfunction : exp_page
  // Refusal expected from the allowed mode and operation lists
  function automatic logic exp_bad(input oag_pkg::oag_req_t q);
    if (q.mode == oag_pkg::MODE_ABS)
      return q.op > oag_pkg::OP_ROR || q.op == oag_pkg::OP_XMA;
    if (q.mode == oag_pkg::MODE_XIND)
      return !(q.op inside {oag_pkg::OP_ADC, oag_pkg::OP_AND,
        oag_pkg::OP_CMP, oag_pkg::OP_EOR, oag_pkg::OP_LDA, oag_pkg::OP_OR,
        oag_pkg::OP_SBC, oag_pkg::OP_STA, oag_pkg::OP_XMA});
    if (q.mode == oag_pkg::MODE_REG)
      return q.rsel > oag_pkg::RSEL_STATUS;
    return q.mode > oag_pkg::MODE_XIND;
  endfunction : exp_bad
  task automatic chk(input logic [39:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Reset clears the pipeline model too
  task automatic do_reset;
    @(posedge sys_clk);
    rst    <= 1'h1;
    req    <= '0;
    acc_en <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk({rsp, clock_timer_control}, 40'h0);
    chk({tmr_rd_hit, bitop_refused, tmr_rd_data}, 40'h0);
    pv = '0;
    pa = 3'h0;
    ce = 8'h00;
  endtask : do_reset
  // One request per edge; outputs of the previous one are compared
  task automatic step(input logic v, input oag_pkg::oag_mode_t m,
                      input oag_pkg::oag_op_t o, input logic [16:0] fx);
    logic [31:0] a, b, c;
    logic        bad;
    a = lfsr(seed);
    b = lfsr(a);
    c = lfsr(b);
    seed = c;
    if (fx[16]) a[23:8] = fx[15:0];
    @(posedge sys_clk);
    req <= '{v, m, o, oag_pkg::oag_rsel_t'(a[2:0]), a[15:8], a[23:16]};
    page_flag <= a[3];
    ram_paging_register <= a[31:24];
    x_index <= c[7:0];
    interval_timer_count <= c[15:8];
    acc_wdata <= c[23:16];
    acc_addr <= c[24] ? oag_pkg::SHARED_TMR_ADDR : c[31:24];
    {acc_en, acc_wr, acc_bitop} <= b[2:0];
    #1;
    chk(rsp.valid, pv.valid);
    bad = exp_bad(pv);
    if (!pv.valid) begin
      chk(rsp, 40'h0);
    end else begin
      case (pv.mode)
        oag_pkg::MODE_ABS: begin
          chk({rsp.illegal, rsp.mem_access}, {bad, !bad});
          if (!bad) chk(rsp.ea, {pv.op2, pv.op1});
        end
        oag_pkg::MODE_XIND: begin
          chk({rsp.illegal, rsp.mem_access}, {bad, !bad});
          if (!bad) chk(rsp.ea, {exp_page(pp, pr), px});
        end
        oag_pkg::MODE_DP:
          chk({rsp.illegal, rsp.mem_access, rsp.ea},
              {2'h1, exp_page(pp, pr), pv.op1});
        oag_pkg::MODE_IMM:
          chk({rsp.illegal, rsp.mem_access, rsp.use_imm, rsp.imm},
              {3'h1, pv.op1});
        oag_pkg::MODE_REG:
          chk({rsp.illegal, rsp.mem_access, rsp.use_reg, rsp.rsel},
              {bad, 2'h1, pv.rsel});
        default:
          chk({rsp.illegal, rsp.mem_access}, {bad, 1'h0});
      endcase
    end
    chk({tmr_rd_hit, bitop_refused, clock_timer_control},
        {pa[2] & ~pa[1], &pa, ce});
    if (pa[2] & ~pa[1]) chk(tmr_rd_data, pt);
    pv = req;
    {pp, pr, px, pt} = {page_flag, ram_paging_register, x_index,
                        interval_timer_count};
    pa = {acc_en && acc_addr == oag_pkg::SHARED_TMR_ADDR, acc_wr, acc_bitop};
    // Bit writes are dropped, so only whole writes move the control byte
    if (pa == 3'h6) ce = acc_wdata;
  endtask : step
  initial begin
    do_reset;
    step(1'h1, oag_pkg::MODE_ABS, oag_pkg::OP_ADC, 17'h1F035);
    step(1'h1, oag_pkg::MODE_ABS, oag_pkg::OP_ROR, 17'h1FFFF);
    step(1'h1, oag_pkg::MODE_DP, oag_pkg::OP_LDA, 17'h100FF);
    for (int m = 0; m < 8; m++)
      for (int o = 0; o < 25; o++)
        step(1'h1, oag_pkg::oag_mode_t'(m), oag_pkg::oag_op_t'(o), 17'h0);
    do_reset;
    repeat (2000)
      step(seed[9], oag_pkg::oag_mode_t'(seed[2:0] % 3'h5),
           oag_pkg::oag_op_t'(seed[8:4] % 5'h19), 17'h0);
    do_reset;
    conclude;
  end
endmodule : oag_top_tb
